/* File: core/cct_pkg.sv */
// package: register map, field layouts and timing constants of the clock and time base unit
// =====================================================================
`default_nettype none

package cct_pkg;

   // =====================================================================
   // bus and register map (byte address is four times the index)
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam logic [APB_AW-3:0] CSR_IDX = 10'h02c;
   localparam logic [APB_AW-3:0] TONE_IDX = 10'h02d;
   localparam logic [APB_AW-3:0] IRQ_ST_IDX = 10'h030;
   localparam logic [APB_AW-3:0] IRQ_MASK_IDX = 10'h031;
   localparam logic [1:0] WORD_LANE = 2'h0;

   // =====================================================================
   // register layouts
   typedef struct packed {
      logic clock_out_enable;
      logic [1:0] slow_divider_select;
      logic slow_mode_select;
      logic [1:0] time_base_select;
      logic timebase_irq_enable;
      logic timebase_irq_flag;
   } cct_csr_t;

   typedef struct packed {
      logic [5:0] reserved;
      logic [1:0] tone_select;
   } cct_tone_t;

   localparam cct_csr_t CSR_RST = 8'h00;
   localparam cct_tone_t TONE_RST = 8'h00;
   localparam logic [5:0] TONE_RSVD_VAL = 6'h00;

   // interrupt status / mask bits
   localparam int IRQ_W = 2;
   localparam int IRQ_EV_PERIOD = 0;
   localparam int IRQ_EV_WAKE = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // register selector returned by the address decoder
   typedef enum logic [4:0] {
      SEL_NONE = 5'b00001,
      SEL_CSR = 5'b00010,
      SEL_TONE = 5'b00100,
      SEL_IRQ_ST = 5'b01000,
      SEL_IRQ_MASK = 5'b10000
   } cct_sel_t;

   // power mode state
   typedef enum logic [2:0] {
      MODE_RUN = 3'b001,
      MODE_TSTOP = 3'b010,
      MODE_DSTOP = 3'b100
   } cct_mode_t;

   // =====================================================================
   // timing
   localparam int TB_CNT_W = 18;
   localparam int TB_PERIOD_0 = 16000;
   localparam int TB_PERIOD_1 = 32000;
   localparam int TB_PERIOD_2 = 80000;
   localparam int TB_PERIOD_3 = 200000;

   // tone half periods are fixed ratios of the oscillator, quoted at 8 MHz
   localparam int TONE_REF_OSC_HZ = 8000000;
   localparam int TONE_HZ_1 = 2000;
   localparam int TONE_HZ_2 = 1000;
   localparam int TONE_HZ_3 = 500;
   localparam int TONE_HALF_1 = TONE_REF_OSC_HZ / (2 * TONE_HZ_1);
   localparam int TONE_HALF_2 = TONE_REF_OSC_HZ / (2 * TONE_HZ_2);
   localparam int TONE_HALF_3 = TONE_REF_OSC_HZ / (2 * TONE_HZ_3);
   localparam int TONE_CNT_W = 13;
   localparam logic [1:0] TONE_OFF = 2'h0;

   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_BASE = 4'h2;

endpackage : cct_pkg

`default_nettype wire

/* File: core/cct_timebase.sv */
// module: time base period counter with deferred period selection
`default_nettype none

module cct_timebase #(
   parameter int P0 = cct_pkg::TB_PERIOD_0,
   parameter int P1 = cct_pkg::TB_PERIOD_1,
   parameter int P2 = cct_pkg::TB_PERIOD_2,
   parameter int P3 = cct_pkg::TB_PERIOD_3
) (
   input wire logic i_clk_sys,   // oscillator clock
   input wire logic i_rst,       // async reset, high
   input wire logic i_en,        // counting allowed
   input wire logic [1:0] i_sel, // requested period code
   output logic o_tick           // one-cycle pulse at period end
);

   logic [cct_pkg::TB_CNT_W-1:0] cnt;
   logic [cct_pkg::TB_CNT_W-1:0] next_cnt;
   logic [1:0] act;
   logic [1:0] next_act;
   logic next_tick;

   function automatic logic [cct_pkg::TB_CNT_W-1:0] last_count(input logic [1:0] s);
      case (s)
         2'h0: last_count = cct_pkg::TB_CNT_W'(P0 - 1);
         2'h1: last_count = cct_pkg::TB_CNT_W'(P1 - 1);
         2'h2: last_count = cct_pkg::TB_CNT_W'(P2 - 1);
         default: last_count = cct_pkg::TB_CNT_W'(P3 - 1);
      endcase
   endfunction : last_count

   always_comb begin
      next_cnt = cnt;
      next_act = act;
      next_tick = 1'b0;
      if (i_en) begin
         if (cnt == last_count(act)) begin
            next_cnt = '0;
            next_tick = 1'b1;
            next_act = i_sel;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0;
         act <= 2'h0;
         o_tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         act <= next_act;
         o_tick <= next_tick;
      end
   end

endmodule : cct_timebase

`default_nettype wire

/* File: core/cct_tone.sv */
// module: square wave tone generator with three selectable pitches
`default_nettype none

module cct_tone #(
   parameter int H1 = cct_pkg::TONE_HALF_1,
   parameter int H2 = cct_pkg::TONE_HALF_2,
   parameter int H3 = cct_pkg::TONE_HALF_3
) (
   input wire logic i_clk_sys,   // oscillator clock
   input wire logic i_rst,       // async reset, high
   input wire logic i_en,        // generator runs
   input wire logic [1:0] i_sel, // tone code, zero is off
   output logic o_tone           // tone level
);

   logic [cct_pkg::TONE_CNT_W-1:0] cnt;
   logic [cct_pkg::TONE_CNT_W-1:0] next_cnt;
   logic [cct_pkg::TONE_CNT_W-1:0] half_last;
   logic next_tone;

   always_comb begin
      case (i_sel)
         2'h1: half_last = cct_pkg::TONE_CNT_W'(H1 - 1);
         2'h2: half_last = cct_pkg::TONE_CNT_W'(H2 - 1);
         default: half_last = cct_pkg::TONE_CNT_W'(H3 - 1);
      endcase
      next_cnt = cnt;
      next_tone = o_tone;
      if (i_en && i_sel == cct_pkg::TONE_OFF) begin
         next_cnt = '0;
         next_tone = 1'b0;
      end else if (i_en) begin
         if (cnt >= half_last) begin
            next_cnt = '0;       // equal halves give 50% duty
            next_tone = ~o_tone;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0;
         o_tone <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_tone <= next_tone;
      end
   end

endmodule : cct_tone

`default_nettype wire

/* File: core/cct_top.sv */
// module: clock controller, time base interrupt and tone output behind an APB slave
`default_nettype none

module cct_top #(
   parameter int TB_SCALE = 1,  // divides every time base period, one keeps real lengths
   parameter int TONE_SCALE = 1 // divides every tone half period, one keeps real pitches
) (
   input wire logic i_clk_sys,                         // oscillator clock
   input wire logic i_rst,                             // async reset, high
   input wire logic i_ce,                              // clock enable, low freezes all
   input wire logic i_psel,                            // apb select
   input wire logic i_penable,                         // apb enable
   input wire logic i_pwrite,                          // apb direction
   input wire logic [cct_pkg::APB_AW-1:0] i_paddr,     // apb byte address
   input wire logic [cct_pkg::APB_DW-1:0] i_pwdata,    // apb write data
   output logic [cct_pkg::APB_DW-1:0] o_prdata,        // apb read data
   output logic o_pready,                              // apb ready
   output logic o_pslverr,                             // apb error
   input wire logic i_stop_req,                        // stop instruction pulse
   input wire logic i_ext_wake,                        // wake able to leave deep stop
   input wire logic i_cpu_irq_masked,                  // cpu interrupt mask active
   output logic o_core_tick,                           // core clock enable
   output logic o_clk_out,                             // clock-out pin level
   output logic o_clk_out_oe,                          // clock-out pin driven
   output logic o_tone,                                // tone pin level
   output logic o_tone_oe,                             // tone pin driven
   output logic o_timebase_irq,                        // time base irq request
   output logic o_irq,                                 // summary irq, level
   output logic o_timed_stop,                          // in timed stop
   output logic o_deep_stop                            // in deep stop
);

   // =====================================================================
   // address decode
   function automatic cct_pkg::cct_sel_t decode(input logic [cct_pkg::APB_AW-1:0] a);
      if (a[1:0] != cct_pkg::WORD_LANE) begin
         decode = cct_pkg::SEL_NONE;
      end else if (a[cct_pkg::APB_AW-1:2] == cct_pkg::CSR_IDX) begin
         decode = cct_pkg::SEL_CSR;
      end else if (a[cct_pkg::APB_AW-1:2] == cct_pkg::TONE_IDX) begin
         decode = cct_pkg::SEL_TONE;
      end else if (a[cct_pkg::APB_AW-1:2] == cct_pkg::IRQ_ST_IDX) begin
         decode = cct_pkg::SEL_IRQ_ST;
      end else if (a[cct_pkg::APB_AW-1:2] == cct_pkg::IRQ_MASK_IDX) begin
         decode = cct_pkg::SEL_IRQ_MASK;
      end else begin
         decode = cct_pkg::SEL_NONE;
      end
   endfunction : decode

   // =====================================================================
   // state
   cct_pkg::cct_csr_t csr;
   cct_pkg::cct_csr_t next_csr;
   cct_pkg::cct_tone_t tone_reg;
   cct_pkg::cct_tone_t next_tone_reg;
   logic [cct_pkg::IRQ_W-1:0] irq_st;
   logic [cct_pkg::IRQ_W-1:0] next_irq_st;
   logic [cct_pkg::IRQ_W-1:0] irq_mask;
   logic [cct_pkg::IRQ_W-1:0] next_irq_mask;
   cct_pkg::cct_mode_t mode;
   cct_pkg::cct_mode_t next_mode;
   logic [cct_pkg::DIV_W-1:0] div_cnt;
   logic [cct_pkg::DIV_W-1:0] next_div_cnt;
   logic [cct_pkg::APB_DW-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic flag_seen;
   logic next_flag_seen;
   logic next_core_tick;
   logic next_clk_out;
   logic next_clk_out_oe;
   logic next_tone_oe;
   logic next_timebase_irq;
   logic next_irq;
   logic tb_tick;
   logic tb_en;
   logic tone_en;
   logic tone_lvl;
   logic wake;
   logic acc;
   logic wr;
   logic rd;
   cct_pkg::cct_sel_t sel;
   logic [cct_pkg::IRQ_W-1:0] ev;
   logic [cct_pkg::DIV_W-1:0] div_last;

   // =====================================================================
   // sub blocks
   assign tb_en = i_ce && (mode != cct_pkg::MODE_DSTOP);
   assign tone_en = i_ce && (mode != cct_pkg::MODE_DSTOP);

   cct_timebase #(
      .P0(cct_pkg::TB_PERIOD_0 / TB_SCALE),
      .P1(cct_pkg::TB_PERIOD_1 / TB_SCALE),
      .P2(cct_pkg::TB_PERIOD_2 / TB_SCALE),
      .P3(cct_pkg::TB_PERIOD_3 / TB_SCALE)
   ) u_tb (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_en(tb_en),
      .i_sel(csr.time_base_select),
      .o_tick(tb_tick)
   );

   cct_tone #(
      .H1(cct_pkg::TONE_HALF_1 / TONE_SCALE),
      .H2(cct_pkg::TONE_HALF_2 / TONE_SCALE),
      .H3(cct_pkg::TONE_HALF_3 / TONE_SCALE)
   ) u_tone (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_en(tone_en),
      .i_sel(tone_reg.tone_select),
      .o_tone(tone_lvl)
   );

   // =====================================================================
   // apb access phase and power mode
   always_comb begin
      sel = decode(i_paddr);
      acc = i_psel && i_penable && o_pready;
      rd = acc && !i_pwrite;
      wr = acc && i_pwrite && (mode == cct_pkg::MODE_RUN);
      wake = 1'b0;
      next_mode = mode;
      case (mode)
         cct_pkg::MODE_RUN: begin
            if (i_stop_req) begin
               if (csr.timebase_irq_enable) begin
                  next_mode = cct_pkg::MODE_TSTOP;
               end else begin
                  next_mode = cct_pkg::MODE_DSTOP;
               end
            end
         end
         cct_pkg::MODE_TSTOP: begin
            if ((tb_tick && csr.timebase_irq_enable) || i_ext_wake) begin
               next_mode = cct_pkg::MODE_RUN;
               wake = 1'b1;
            end
         end
         cct_pkg::MODE_DSTOP: begin
            if (i_ext_wake) begin
               next_mode = cct_pkg::MODE_RUN;
               wake = 1'b1;
            end
         end
         default: begin
            next_mode = cct_pkg::MODE_RUN;
         end
      endcase
   end

   // =====================================================================
   // registers
   always_comb begin
      next_csr = csr;
      next_tone_reg = tone_reg;
      next_irq_mask = irq_mask;
      ev = '0;
      ev[cct_pkg::IRQ_EV_PERIOD] = tb_tick;
      ev[cct_pkg::IRQ_EV_WAKE] = wake;
      next_irq_st = irq_st;
      if (wr && sel == cct_pkg::SEL_CSR) begin
         next_csr = cct_pkg::cct_csr_t'(i_pwdata[7:0]);
         next_csr.timebase_irq_flag = csr.timebase_irq_flag; // flag is read-only
      end
      if (wr && sel == cct_pkg::SEL_TONE) begin
         next_tone_reg.tone_select = i_pwdata[1:0];
         next_tone_reg.reserved = cct_pkg::TONE_RSVD_VAL;
      end
      if (wr && sel == cct_pkg::SEL_IRQ_MASK) begin
         next_irq_mask = i_pwdata[cct_pkg::IRQ_W-1:0];
      end
      if (wr && sel == cct_pkg::SEL_IRQ_ST) begin
         next_irq_st = irq_st & ~i_pwdata[cct_pkg::IRQ_W-1:0];
      end
      next_irq_st = next_irq_st | ev; // set wins over clear
      // only a flag value that was actually returned is cleared
      if (rd && sel == cct_pkg::SEL_CSR && flag_seen) begin
         next_csr.timebase_irq_flag = 1'b0;
      end
      if (tb_tick) begin
         next_csr.timebase_irq_flag = 1'b1;
      end
      next_timebase_irq = next_csr.timebase_irq_flag && next_csr.timebase_irq_enable &&
                          !i_cpu_irq_masked;
      next_irq = |(next_irq_st & next_irq_mask);
   end

   // =====================================================================
   // apb answer: one wait state, data captured as ready rises
   always_comb begin
      next_pready = i_psel && i_penable && !o_pready;
      next_pslverr = 1'b0;
      next_prdata = '0;
      next_flag_seen = 1'b0;
      if (next_pready) begin
         if (sel == cct_pkg::SEL_CSR) begin
            next_prdata = cct_pkg::APB_DW'(csr);
            next_flag_seen = csr.timebase_irq_flag;
         end else if (sel == cct_pkg::SEL_TONE) begin
            next_prdata = cct_pkg::APB_DW'(tone_reg);
         end else if (sel == cct_pkg::SEL_IRQ_ST) begin
            next_prdata = cct_pkg::APB_DW'(irq_st);
         end else if (sel == cct_pkg::SEL_IRQ_MASK) begin
            next_prdata = cct_pkg::APB_DW'(irq_mask);
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   // =====================================================================
   // core clock enable and pins
   always_comb begin
      div_last = (cct_pkg::DIV_BASE << csr.slow_divider_select) - 1'b1;
      next_div_cnt = div_cnt;
      next_core_tick = 1'b0;
      if (mode == cct_pkg::MODE_RUN) begin
         if (!csr.slow_mode_select) begin
            next_div_cnt = '0;
            next_core_tick = 1'b1;
         end else if (div_cnt >= div_last) begin
            next_div_cnt = '0;
            next_core_tick = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 1'b1;
         end
      end
      next_clk_out_oe = csr.clock_out_enable && (mode == cct_pkg::MODE_RUN);
      next_clk_out = next_clk_out_oe && next_core_tick;
      next_tone_oe = (tone_reg.tone_select != cct_pkg::TONE_OFF);
   end

   // =====================================================================
   // state registers, all frozen while the clock enable is low
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         csr <= cct_pkg::CSR_RST;
         tone_reg <= cct_pkg::TONE_RST;
         irq_st <= cct_pkg::IRQ_RST;
         irq_mask <= cct_pkg::IRQ_RST;
         o_timebase_irq <= 1'b0;
         o_irq <= 1'b0;
      end else if (i_ce) begin
         csr <= next_csr;
         tone_reg <= next_tone_reg;
         irq_st <= next_irq_st;
         irq_mask <= next_irq_mask;
         o_timebase_irq <= next_timebase_irq;
         o_irq <= next_irq;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mode <= cct_pkg::MODE_RUN;
         o_timed_stop <= 1'b0;
         o_deep_stop <= 1'b0;
      end else if (i_ce) begin
         mode <= next_mode;
         o_timed_stop <= (next_mode == cct_pkg::MODE_TSTOP);
         o_deep_stop <= (next_mode == cct_pkg::MODE_DSTOP);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         flag_seen <= 1'b0;
         o_prdata <= '0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else if (i_ce) begin
         flag_seen <= next_flag_seen;
         o_prdata <= next_prdata;
         o_pready <= next_pready;
         o_pslverr <= next_pslverr;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         div_cnt <= '0;
         o_core_tick <= 1'b0;
         o_clk_out <= 1'b0;
         o_clk_out_oe <= 1'b0;
         o_tone <= 1'b0;
         o_tone_oe <= 1'b0;
      end else if (i_ce) begin
         div_cnt <= next_div_cnt;
         o_core_tick <= next_core_tick;
         o_clk_out <= next_clk_out;
         o_clk_out_oe <= next_clk_out_oe;
         o_tone <= tone_lvl;
         o_tone_oe <= next_tone_oe;
      end
   end

endmodule : cct_top

`default_nettype wire

/* File: bench/cct_top_properties.sv */
// checker: port properties of the clock controller, time base and tone unit
`default_nettype none

module cct_top_properties (
   input wire logic i_clk_sys,        // clock
   input wire logic i_rst,            // reset
   input wire logic i_ce,             // clock enable
   input wire logic i_psel,           // apb select
   input wire logic i_penable,        // apb enable
   input wire logic i_ext_wake,       // deep stop wake
   input wire logic i_cpu_irq_masked, // cpu mask
   input wire logic o_pready,         // apb ready
   input wire logic o_pslverr,        // apb error
   input wire logic o_core_tick,      // core enable
   input wire logic o_clk_out,        // clock-out level
   input wire logic o_clk_out_oe,     // clock-out driven
   input wire logic o_tone,           // tone level
   input wire logic o_tone_oe,        // tone driven
   input wire logic o_timebase_irq,   // time base irq
   input wire logic o_timed_stop,     // timed stop
   input wire logic o_deep_stop       // deep stop
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // =====================================================================
   // apb handshake
   sequence apb_setup_s; i_ce && i_psel && !i_penable; endsequence
   sequence apb_wait_s; i_ce && i_psel && i_penable && !o_pready; endsequence
   ready_wait_a: assert property (apb_setup_s ##1 apb_wait_s |=> o_pready)
      else $error("ready not on second access cycle");
   ready_pulse_a: assert property (i_ce && o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");

   // =====================================================================
   // pins, interrupt and power modes
   irq_gate_a: assert property (i_ce && i_cpu_irq_masked |=> !o_timebase_irq)
      else $error("time base irq while cpu masked");
   clkout_stop_a: assert property (o_timed_stop && $past(o_timed_stop) |-> !o_clk_out_oe)
      else $error("clock-out driven in timed stop");
   clkout_drive_a: assert property (o_clk_out |-> o_clk_out_oe || $past(o_clk_out_oe))
      else $error("clock-out level while pin not driven");
   stop_tick_a: assert property ((o_timed_stop || o_deep_stop)
      && $past(o_timed_stop || o_deep_stop) |-> !o_core_tick)
      else $error("core tick during stop");
   deep_hold_a: assert property (o_deep_stop && i_ce && !i_ext_wake
      && !$past(i_ext_wake) |=> o_deep_stop)
      else $error("deep stop left without wake");
   tone_off_a: assert property (!o_tone_oe && !$past(o_tone_oe) |-> !o_tone)
      else $error("tone level while off");
   modes_excl_a: assert property (!(o_timed_stop && o_deep_stop))
      else $error("both stop modes at once");
endmodule : cct_top_properties

`default_nettype wire

/* File: bench/cct_top_tb.sv */
// testbench: random and corner stimulus for the clock controller over apb
`default_nettype none

module cct_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PER[4] = '{16, 32, 80, 200};
   localparam int HALF[4] = '{0, 4, 8, 16};
   localparam logic [11:0] A_CSR = {cct_pkg::CSR_IDX, cct_pkg::WORD_LANE};
   localparam logic [11:0] A_TONE = {cct_pkg::TONE_IDX, cct_pkg::WORD_LANE};
   localparam logic [11:0] A_IST = {cct_pkg::IRQ_ST_IDX, cct_pkg::WORD_LANE};
   localparam logic [11:0] A_IMK = {cct_pkg::IRQ_MASK_IDX, cct_pkg::WORD_LANE};
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
   logic i_pwrite = 1'b0, i_stop_req = 1'b0, i_ext_wake = 1'b0, i_cpu_irq_masked = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic o_pready, o_pslverr, o_core_tick, o_clk_out, o_clk_out_oe, o_tone, o_tone_oe, er;
   logic o_timebase_irq, o_irq, o_timed_stop, o_deep_stop;
   logic [7:0] lfsr = 8'h1d;
   int num_errors = 0, cmp_count = 0, cyc = 0, t0, t1, n;

   cct_top #(.TB_SCALE(1000), .TONE_SCALE(500)) DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_ce(i_ce), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_stop_req(i_stop_req), .i_ext_wake(i_ext_wake), .i_cpu_irq_masked(i_cpu_irq_masked),
      .o_core_tick(o_core_tick), .o_clk_out(o_clk_out), .o_clk_out_oe(o_clk_out_oe),
      .o_tone(o_tone), .o_tone_oe(o_tone_oe), .o_timebase_irq(o_timebase_irq), .o_irq(o_irq),
      .o_timed_stop(o_timed_stop), .o_deep_stop(o_deep_stop));

   always #50 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) cyc <= cyc + 1;

   // =====================================================================
   // helpers
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
      int k;
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= {24'h0, wd};
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_clk_sys);
         k++;
      end while (o_pready !== 1'b1 && k < 20);
      rd = o_prdata;
      er = o_pslverr;
      if (k >= 20) num_errors++;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task automatic measure(output int t);
      for (n = 0; n < 400 && o_irq !== 1'b1; n++) @(posedge i_clk_sys);
      t = cyc;
      apb(1'b1, A_IST, 8'h01);
      repeat (3) @(posedge i_clk_sys);
   endtask : measure

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   // =====================================================================
   // main sequence
   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      apb(1'b0, A_CSR, 8'h00); check("csr reset", rd, 32'h0);
      apb(1'b0, A_TONE, 8'h00); check("tone reset", rd, 32'h0);
      apb(1'b0, 12'h0f0, 8'h00); check("unmapped error", {31'h0, er}, 32'h1);
      for (int c = 1; c < 4; c++) begin
         lfsr = lfsr_next(lfsr);
         apb(1'b1, A_TONE, {6'h0, 2'(c)});
         apb(1'b0, A_TONE, 8'h00); check("tone readback", rd, 32'(c));
         for (n = 0; n < 200 && o_tone !== 1'b1; n++) @(posedge i_clk_sys);
         for (n = 0; n < 200 && o_tone !== 1'b0; n++) @(posedge i_clk_sys);
         t0 = cyc;
         for (n = 0; n < 200 && o_tone !== 1'b1; n++) @(posedge i_clk_sys);
         check("tone half period", 32'(cyc - t0), 32'(HALF[c]));
      end
      apb(1'b1, A_TONE, 8'h00);
      repeat (4) @(posedge i_clk_sys);
      check("tone off", {o_tone_oe, o_tone}, 32'h0);
      for (int k = 0; k < 5; k++) begin
         apb(1'b1, A_CSR, (k == 4) ? 8'h00 : {1'b1, 2'(k), 1'b1, 4'h0});
         repeat (4) @(posedge i_clk_sys);
         t0 = 0;
         repeat (32) begin
            @(posedge i_clk_sys);
            if (o_core_tick === 1'b1) t0++;
         end
         check("core ticks", 32'(t0), (k == 4) ? 32'd32 : 32'(32 / (2 << k)));
         check("clock-out drive", {31'h0, o_clk_out_oe}, 32'(k < 4));
      end
      apb(1'b1, A_IMK, 8'h01);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, A_CSR, {4'h0, 2'(c), 2'h0});
         repeat (2) measure(t0);
         measure(t0);
         measure(t1);
         check("period", 32'(t1 - t0), 32'(PER[c]));
      end
      apb(1'b1, A_CSR, 8'h00);
      measure(t0); check("deferred select", 32'(t0 - t1), 32'd200);
      measure(t1); check("new period", 32'(t1 - t0), 32'd16);
      apb(1'b1, A_IMK, 8'h00);
      repeat (20) @(posedge i_clk_sys);
      check("masked irq", {31'h0, o_irq}, 32'h0);
      apb(1'b0, A_IST, 8'h00); check("status period bit", {31'h0, rd[0]}, 32'h1);
      lfsr = lfsr_next(lfsr);
      apb(1'b1, A_IMK, {6'h0, lfsr[1:0]});
      apb(1'b0, A_IMK, 8'h00); check("mask readback", rd, {30'h0, lfsr[1:0]});
      apb(1'b1, A_IMK, 8'h00);
      apb(1'b1, A_CSR, 8'h02);
      for (n = 0; n < 40 && o_timebase_irq !== 1'b1; n++) @(posedge i_clk_sys);
      apb(1'b0, A_CSR, 8'h00); check("flag set", rd, 32'h03);
      apb(1'b0, A_CSR, 8'h00);
      for (n = 0; n < 40 && o_timebase_irq !== 1'b1; n++) @(posedge i_clk_sys);
      apb(1'b0, A_CSR, 8'h00); check("fresh flag", rd, 32'h03);
      repeat (3) @(posedge i_clk_sys);
      check("irq drops", {31'h0, o_timebase_irq}, 32'h0);
      apb(1'b0, A_CSR, 8'h00); check("flag cleared", rd, 32'h02);
      i_cpu_irq_masked <= 1'b1;
      repeat (40) @(posedge i_clk_sys);
      check("cpu masked", {31'h0, o_timebase_irq}, 32'h0);
      i_cpu_irq_masked <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      check("pending irq", {31'h0, o_timebase_irq}, 32'h1);
      apb(1'b1, A_TONE, 8'h01);
      apb(1'b1, A_CSR, 8'h82);
      apb(1'b0, A_CSR, 8'h00);
      for (n = 0; n < 40 && o_timebase_irq !== 1'b1; n++) @(posedge i_clk_sys);
      i_stop_req <= 1'b1;
      @(posedge i_clk_sys);
      i_stop_req <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      check("timed stop", {o_timed_stop, o_deep_stop, o_clk_out_oe}, 32'h4);
      t1 = 0;
      repeat (6) begin
         er = o_tone;
         @(posedge i_clk_sys);
         if (o_tone !== er) t1++;
      end
      check("tone in timed stop", 32'(t1 > 0), 32'h1);
      for (n = 0; n < 30 && o_timed_stop !== 1'b0; n++) @(posedge i_clk_sys);
      check("timed stop wake", {31'h0, o_timed_stop}, 32'h0);
      apb(1'b1, A_CSR, 8'h00);
      i_stop_req <= 1'b1;
      @(posedge i_clk_sys);
      i_stop_req <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      check("deep stop", {o_timed_stop, o_deep_stop}, 32'h1);
      apb(1'b1, A_CSR, 8'h80);
      apb(1'b0, A_CSR, 8'h00); check("frozen csr", rd & 32'hfe, 32'h0);
      repeat (250) @(posedge i_clk_sys);
      check("no period wake", {31'h0, o_deep_stop}, 32'h1);
      i_ext_wake <= 1'b1;
      @(posedge i_clk_sys);
      i_ext_wake <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      check("deep wake", {31'h0, o_deep_stop}, 32'h0);
      apb(1'b0, A_IST, 8'h00); check("wake status", {31'h0, rd[1]}, 32'h1);
      results();
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      num_errors++;
      results();
   end
endmodule : cct_top_tb

bind cct_top cct_top_properties u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
   .i_psel(i_psel), .i_penable(i_penable), .i_ext_wake(i_ext_wake),
   .i_cpu_irq_masked(i_cpu_irq_masked), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_core_tick(o_core_tick), .o_clk_out(o_clk_out), .o_clk_out_oe(o_clk_out_oe),
   .o_tone(o_tone), .o_tone_oe(o_tone_oe), .o_timebase_irq(o_timebase_irq),
   .o_timed_stop(o_timed_stop), .o_deep_stop(o_deep_stop));

`default_nettype wire
